// ### core/ckrs_pkg.sv
// Register map and field layout of the clock flag and reset block
package ckrs_pkg;
  localparam int unsigned CKRS_AW = 8;
  // Register byte offsets
  localparam logic [CKRS_AW-1:0] CKRS_OFF_INT = 8'h08;
  localparam logic [CKRS_AW-1:0] CKRS_OFF_RST = 8'h0C;
  localparam logic [CKRS_AW-1:0] CKRS_OFF_MON = 8'h20;
  localparam logic [CKRS_AW-1:0] CKRS_OFF_IEN = 8'h24;
  // Interrupt control register fields
  localparam int unsigned CKRS_NFLAG = 8;
  localparam int unsigned CKRS_NRDY = 5;
  localparam int unsigned CKRS_FLAG_LSB = 0;
  localparam int unsigned CKRS_EN_LSB = 8;
  localparam int unsigned CKRS_NEN = 7;
  localparam int unsigned CKRS_CLR_LSB = 16;
  localparam int unsigned CKRS_HS_STUCK = 7;
  localparam int unsigned CKRS_LOOP_STUCK = 6;
  localparam int unsigned CKRS_LOW_STUCK = 5;
  localparam int unsigned CKRS_LOOP_RDY = 4;
  localparam int unsigned CKRS_HS_RDY = 3;
  localparam int unsigned CKRS_I8M_RDY = 2;
  localparam int unsigned CKRS_LOW_RDY = 1;
  localparam int unsigned CKRS_I40K_RDY = 0;
  // Monitor control register
  localparam int unsigned CKRS_NMI_BIT = 0;
  // Peripheral reset register bits
  localparam int unsigned CKRS_CAN_B = 31;
  localparam int unsigned CKRS_CAN_A = 30;
  localparam int unsigned CKRS_TIM_D = 21;
  localparam int unsigned CKRS_TIM_C = 20;
  localparam int unsigned CKRS_SXCVR = 14;
  localparam int unsigned CKRS_TIM_B = 13;
  localparam int unsigned CKRS_SPER = 12;
  localparam int unsigned CKRS_TIM_A = 11;
  localparam int unsigned CKRS_CONV_B = 10;
  localparam int unsigned CKRS_CONV_A = 9;
  localparam int unsigned CKRS_CMP = 1;
  localparam int unsigned CKRS_SYSCFG = 0;
  localparam logic [31:0] CKRS_RST_MASK = 32'hC0307E03;
  localparam logic [31:0] CKRS_RST_INIT = 32'h00000000;
  localparam logic [31:0] CKRS_ZERO = 32'h00000000;
endpackage : ckrs_pkg

// ### core/ckrs_top.sv
// Clock interrupt flags and fast-bus peripheral reset register, APB slave
//
// Overview of operation
// RL1: Ready-interrupt enables at bits 12 to 8.
// RL2: Hardware sets bit 7 on crystal stuck.
// RL3: Clear bit 23 write-one clears crystal stuck.
// RL4: Setting monitor NMI enable clears crystal stuck.
// RL5: Loop stuck sets bit 6; bit 22 clears.
// RL6: Low crystal stuck sets bit 5; bit 21 clears.
// RL7: Loop ready flag needs loop ready enable.
// RL8: Bit 20 write-one clears loop ready flag.
// RL9: Crystal ready flag bit 3, gated, cleared.
// RL10: Internal 8 MHz ready flag bit 2.
// RL11: Low crystal ready flag bit 1.
// RL12: Internal 40 kHz ready flag bit 0.
// RL13: Bits 31, 30 hold network controllers reset.
// RL14: Bits 21, 20, 13, 11 reset timers.
// RL15: Bit 14 transceiver, bit 12 serial reset.
// RL16: Bits 10, 9 converters, bit 1 comparator.
// RL17: Bit 0 resets system configuration block.
// RL18: Reserved reset bits stay zero.
// RL19: Interrupt high while enabled flag set.
`timescale 1ns/10ps
module ckrs_top
  import ckrs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CKRS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator and monitor status
  input wire logic hsxtal_stuck_det,
  input wire logic loop_stuck_det,
  input wire logic lowxtal_stuck_det,
  input wire logic loop_stable,
  input wire logic hsxtal_stable,
  input wire logic int8m_stable,
  input wire logic lowxtal_stable,
  input wire logic int40k_stable,
  // Interrupt request
  output logic clk_irq,
  // Peripheral reset lines
  output logic can_b_reset,
  output logic can_a_reset,
  output logic timer_d_reset,
  output logic timer_c_reset,
  output logic serial_xcvr_reset,
  output logic timer_b_reset,
  output logic serial_periph_reset,
  output logic timer_a_reset,
  output logic converter_b_reset,
  output logic converter_a_reset,
  output logic comparator_reset,
  output logic sysconfig_reset
);

  // Address match on a word-aligned offset
  function automatic logic hit(input logic [CKRS_AW-1:0] a, input logic [CKRS_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic [CKRS_NFLAG-1:0] flags;
  logic [CKRS_NEN-1:0] int_en;
  logic [CKRS_NFLAG-1:0] irq_en;
  logic clkmon_nmi_enable;
  logic [31:0] rst_reg;
  logic [CKRS_NFLAG-1:0] det_prev;
  logic [CKRS_NFLAG-1:0] det_now;
  logic [CKRS_NFLAG-1:0] det_rise;
  logic [CKRS_NFLAG-1:0] next_set;
  logic [CKRS_NFLAG-1:0] next_clr;
  logic [31:0] next_rdata;
  logic acc;
  logic wr;
  logic mapped;

  // Named views of the enable field
  logic int8m_ready_irq_en;
  logic lowxtal_ready_irq_en;
  logic int40k_ready_irq_en;
  logic loop_ready_irq_en;
  logic hsxtal_ready_irq_en;
  assign loop_ready_irq_en = int_en[CKRS_LOOP_RDY];
  assign hsxtal_ready_irq_en = int_en[CKRS_HS_RDY];
  assign int8m_ready_irq_en = int_en[CKRS_I8M_RDY];
  assign lowxtal_ready_irq_en = int_en[CKRS_LOW_RDY];
  assign int40k_ready_irq_en = int_en[CKRS_I40K_RDY];

  // Access phase and the edge at which it completes
  assign acc = psel & penable;
  assign wr = acc & pready & pwrite;
  assign mapped = hit(paddr, CKRS_OFF_INT) | hit(paddr, CKRS_OFF_RST) |
                  hit(paddr, CKRS_OFF_MON) | hit(paddr, CKRS_OFF_IEN);

  // Monitor inputs in flag order
  assign det_now = {hsxtal_stuck_det, loop_stuck_det, lowxtal_stuck_det, loop_stable,
                    hsxtal_stable, int8m_stable, lowxtal_stable, int40k_stable};
  assign det_rise = det_now & ~det_prev;

  // Edge history so a level held high does not refire after a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      det_prev <= '0;
    end else begin
      det_prev <= det_now;
    end
  end

  // Set and clear terms; ready flags are gated by their enables
  always_comb begin
    next_set = det_rise;  // [RL2] [RL5] [RL6]
    next_set[CKRS_NRDY-1:0] = det_rise[CKRS_NRDY-1:0] & int_en[CKRS_NRDY-1:0];  // [RL7] [RL9] [RL10] [RL11] [RL12]
    next_clr = '0;
    if (wr && hit(paddr, CKRS_OFF_INT)) begin
      next_clr = pwdata[CKRS_CLR_LSB +: CKRS_NFLAG];  // [RL3] [RL8]
    end
    if (wr && hit(paddr, CKRS_OFF_MON) && pwdata[CKRS_NMI_BIT]) begin
      next_clr[CKRS_HS_STUCK] = 1'b1;  // [RL4]
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~next_clr) | next_set;  // [RL3] [RL5] [RL6] [RL8]
    end
  end

  // Enable field of the interrupt control register
  always_ff @(posedge clk) begin
    if (rst) begin
      int_en <= '0;
    end else if (wr && hit(paddr, CKRS_OFF_INT)) begin
      int_en <= pwdata[CKRS_EN_LSB +: CKRS_NEN];  // [RL1]
    end
  end

  // Monitor control and interrupt mask registers
  always_ff @(posedge clk) begin
    if (rst) begin
      clkmon_nmi_enable <= 1'b0;
      irq_en <= '0;
    end else begin
      if (wr && hit(paddr, CKRS_OFF_MON)) begin
        clkmon_nmi_enable <= pwdata[CKRS_NMI_BIT];
      end
      if (wr && hit(paddr, CKRS_OFF_IEN)) begin
        irq_en <= pwdata[CKRS_NFLAG-1:0];
      end
    end
  end

  // Peripheral reset register; reserved bits cannot be set
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_reg <= CKRS_RST_INIT;
    end else if (wr && hit(paddr, CKRS_OFF_RST)) begin
      rst_reg <= pwdata & CKRS_RST_MASK;  // [RL18]
    end
  end

  // Reset lines are the register bits themselves
  assign can_b_reset = rst_reg[CKRS_CAN_B];  // [RL13]
  assign can_a_reset = rst_reg[CKRS_CAN_A];  // [RL13]
  assign timer_d_reset = rst_reg[CKRS_TIM_D];  // [RL14]
  assign timer_c_reset = rst_reg[CKRS_TIM_C];  // [RL14]
  assign timer_b_reset = rst_reg[CKRS_TIM_B];  // [RL14]
  assign timer_a_reset = rst_reg[CKRS_TIM_A];  // [RL14]
  assign serial_xcvr_reset = rst_reg[CKRS_SXCVR];  // [RL15]
  assign serial_periph_reset = rst_reg[CKRS_SPER];  // [RL15]
  assign converter_b_reset = rst_reg[CKRS_CONV_B];  // [RL16]
  assign converter_a_reset = rst_reg[CKRS_CONV_A];  // [RL16]
  assign comparator_reset = rst_reg[CKRS_CMP];  // [RL16]
  assign sysconfig_reset = rst_reg[CKRS_SYSCFG];  // [RL17]

  // Registered request; one cycle behind the flags to keep it glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_irq <= 1'b0;
    end else begin
      clk_irq <= |(flags & irq_en);  // [RL19]
    end
  end

  // Read mux; clear bits read as zero
  always_comb begin
    next_rdata = CKRS_ZERO;
    if (hit(paddr, CKRS_OFF_INT)) begin
      next_rdata[CKRS_FLAG_LSB +: CKRS_NFLAG] = flags;
      next_rdata[CKRS_EN_LSB +: CKRS_NEN] = int_en;
    end else if (hit(paddr, CKRS_OFF_RST)) begin
      next_rdata = rst_reg;
    end else if (hit(paddr, CKRS_OFF_MON)) begin
      next_rdata[CKRS_NMI_BIT] = clkmon_nmi_enable;
    end else if (hit(paddr, CKRS_OFF_IEN)) begin
      next_rdata[CKRS_NFLAG-1:0] = irq_en;
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= CKRS_ZERO;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (acc && !pready && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // Checks

  property p_hs_stuck_set;
    @(posedge clk) disable iff (rst)
    $rose(hsxtal_stuck_det) |=> flags[CKRS_HS_STUCK];
  endproperty
  a_hs_stuck_set: assert property (p_hs_stuck_set) else $error("crystal stuck flag not set");  // [RL2]

  property p_hs_stuck_clr;
    @(posedge clk) disable iff (rst)
    (wr && hit(paddr, CKRS_OFF_INT) && pwdata[CKRS_CLR_LSB + CKRS_HS_STUCK] && !det_rise[CKRS_HS_STUCK])
      |=> !flags[CKRS_HS_STUCK];
  endproperty
  a_hs_stuck_clr: assert property (p_hs_stuck_clr) else $error("crystal stuck flag not cleared");  // [RL3]

  property p_nmi_clr;
    @(posedge clk) disable iff (rst)
    (wr && hit(paddr, CKRS_OFF_MON) && pwdata[CKRS_NMI_BIT] && !det_rise[CKRS_HS_STUCK])
      |=> !flags[CKRS_HS_STUCK] && clkmon_nmi_enable;
  endproperty
  a_nmi_clr: assert property (p_nmi_clr) else $error("nmi enable did not clear stuck flag");  // [RL4]

  property p_loop_stuck;
    @(posedge clk) disable iff (rst)
    $rose(loop_stuck_det) |=> flags[CKRS_LOOP_STUCK];
  endproperty
  a_loop_stuck: assert property (p_loop_stuck) else $error("loop stuck flag not set");  // [RL5]

  property p_low_stuck;
    @(posedge clk) disable iff (rst)
    $rose(lowxtal_stuck_det) |=> flags[CKRS_LOW_STUCK];
  endproperty
  a_low_stuck: assert property (p_low_stuck) else $error("low crystal stuck flag not set");  // [RL6]

  property p_ready_gated;
    @(posedge clk) disable iff (rst)
    $rose(flags[CKRS_LOOP_RDY]) |-> $past(loop_ready_irq_en) && $past(loop_stable);
  endproperty
  a_ready_gated: assert property (p_ready_gated) else $error("loop ready flag set while disabled");  // [RL7]

  property p_i40k_ready;
    @(posedge clk) disable iff (rst)
    ($rose(int40k_stable) && int40k_ready_irq_en) |=> flags[CKRS_I40K_RDY];
  endproperty
  a_i40k_ready: assert property (p_i40k_ready) else $error("40k ready flag missed");  // [RL12]

  property p_can_reset;
    @(posedge clk) disable iff (rst)
    (wr && hit(paddr, CKRS_OFF_RST)) |=> can_b_reset == $past(pwdata[CKRS_CAN_B])
      && sysconfig_reset == $past(pwdata[CKRS_SYSCFG]);
  endproperty
  a_can_reset: assert property (p_can_reset) else $error("reset line does not follow write");  // [RL13]

  property p_reserved;
    @(posedge clk) disable iff (rst)
    (rst_reg & ~CKRS_RST_MASK) == CKRS_ZERO;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved reset bit set");  // [RL18]

  property p_irq;
    @(posedge clk) disable iff (rst)
    ##1 clk_irq == (($past(flags) & $past(irq_en)) != '0);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");  // [RL19]

  property p_en_write;
    @(posedge clk) disable iff (rst)
    (wr && hit(paddr, CKRS_OFF_INT)) |=> int_en == $past(pwdata[CKRS_EN_LSB +: CKRS_NEN]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("ready enables not written");  // [RL1]

  property p_en_hold;
    @(posedge clk) disable iff (rst)
    !(wr && hit(paddr, CKRS_OFF_INT)) |=> $stable(int_en);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("ready enables moved without a write");  // [RL1]

  // A written clear bit leaves its flag low unless a new event lands on the same edge
  property p_sw_clear;
    @(posedge clk) disable iff (rst)
    (wr && hit(paddr, CKRS_OFF_INT)) |=>
      (flags & $past(pwdata[CKRS_CLR_LSB +: CKRS_NFLAG]) & ~$past(det_rise)) == '0;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("flag kept after clear");  // [RL3] [RL5] [RL6] [RL8] [RL9]

  // Flags are sticky: they rise only on an event and fall only on a clear
  property p_set_cause;
    @(posedge clk) disable iff (rst)
    (flags & ~$past(flags) & ~$past(det_rise)) == '0;
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("flag rose without an event");  // [RL2] [RL5] [RL6]

  property p_clr_cause;
    @(posedge clk) disable iff (rst)
    ($past(flags) & ~flags & ~$past(next_clr)) == '0;
  endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("flag fell without a clear");  // [RL2] [RL5] [RL6]

  property p_loop_ready;
    @(posedge clk) disable iff (rst)
    ($rose(loop_stable) && loop_ready_irq_en) |=> flags[CKRS_LOOP_RDY];
  endproperty
  a_loop_ready: assert property (p_loop_ready) else $error("loop ready flag missed");  // [RL7]

  property p_hs_ready;
    @(posedge clk) disable iff (rst)
    ($rose(hsxtal_stable) && hsxtal_ready_irq_en) |=> flags[CKRS_HS_RDY];
  endproperty
  a_hs_ready: assert property (p_hs_ready) else $error("crystal ready flag missed");  // [RL9]

  property p_i8m_ready;
    @(posedge clk) disable iff (rst)
    ($rose(int8m_stable) && int8m_ready_irq_en) |=> flags[CKRS_I8M_RDY];
  endproperty
  a_i8m_ready: assert property (p_i8m_ready) else $error("8 MHz ready flag missed");  // [RL10]

  property p_low_ready;
    @(posedge clk) disable iff (rst)
    ($rose(lowxtal_stable) && lowxtal_ready_irq_en) |=> flags[CKRS_LOW_RDY];
  endproperty
  a_low_ready: assert property (p_low_ready) else $error("low crystal ready flag missed");  // [RL11]

  property p_rdy_gate;
    @(posedge clk) disable iff (rst)
    (flags[CKRS_NRDY-1:0] & ~$past(flags[CKRS_NRDY-1:0]) & ~$past(int_en[CKRS_NRDY-1:0])) == '0;
  endproperty
  a_rdy_gate: assert property (p_rdy_gate) else $error("ready flag set while disabled");  // [RL9] [RL10] [RL11] [RL12]

  property p_rst_follow;
    @(posedge clk) disable iff (rst)
    (wr && hit(paddr, CKRS_OFF_RST)) |=> rst_reg == ($past(pwdata) & CKRS_RST_MASK);
  endproperty
  a_rst_follow: assert property (p_rst_follow) else $error("reset bits do not follow write");  // [RL14] [RL15] [RL16]

  property p_rst_hold;
    @(posedge clk) disable iff (rst)
    !(wr && hit(paddr, CKRS_OFF_RST)) |=> $stable(rst_reg);
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset bits moved without a write");  // [RL13]

  property p_slverr;
    @(posedge clk) disable iff (rst)
    pslverr |-> pready && !mapped;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error response on a mapped access");

  property p_pready;
    @(posedge clk) disable iff (rst)
    $rose(acc) |=> pready ##1 !pready;
  endproperty
  a_pready: assert property (p_pready) else $error("pready timing wrong");

endmodule : ckrs_top

// ### dv/tb.sv
// Self-checking bench for the clock flag and peripheral reset block
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import ckrs_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, clk_irq;
  logic [CKRS_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, en, rst_out;
  logic [7:0] ev;
  logic can_b_reset, can_a_reset, timer_d_reset, timer_c_reset, serial_xcvr_reset, timer_b_reset;
  logic serial_periph_reset, timer_a_reset, converter_b_reset, converter_a_reset, comparator_reset, sysconfig_reset;
  int fails, compares, i;

  // Reset lines gathered in register bit order
  assign rst_out = {can_b_reset, can_a_reset, 8'h00, timer_d_reset, timer_c_reset, 5'h00, serial_xcvr_reset,
    timer_b_reset, serial_periph_reset, timer_a_reset, converter_b_reset, converter_a_reset, 7'h00,
    comparator_reset, sysconfig_reset};

  ckrs_top i_ckrs_top (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsxtal_stuck_det(ev[7]), .loop_stuck_det(ev[6]), .lowxtal_stuck_det(ev[5]), .loop_stable(ev[4]),
    .hsxtal_stable(ev[3]), .int8m_stable(ev[2]), .lowxtal_stable(ev[1]), .int40k_stable(ev[0]),
    .clk_irq(clk_irq), .can_b_reset(can_b_reset), .can_a_reset(can_a_reset), .timer_d_reset(timer_d_reset),
    .timer_c_reset(timer_c_reset), .serial_xcvr_reset(serial_xcvr_reset), .timer_b_reset(timer_b_reset),
    .serial_periph_reset(serial_periph_reset), .timer_a_reset(timer_a_reset),
    .converter_b_reset(converter_b_reset), .converter_a_reset(converter_a_reset),
    .comparator_reset(comparator_reset), .sysconfig_reset(sysconfig_reset)
  );

  // Only the named peripheral bits survive a write
  function automatic logic [31:0] exp_rst(input logic [31:0] v);
    return v & 32'hC0307E03;
  endfunction : exp_rst

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // One APB transfer; an idle edge first keeps back-to-back calls race free
  task automatic apb(input logic wr, input logic [CKRS_AW-1:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      $display("[ERR] %0t no ready", $time);
      wrap_up();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // Rising edge on one status input, then back low
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    repeat (2) @(posedge clk);
    ev[k] <= 1'b0;
  endtask : pulse

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ev = '0;
    fails = 0;
    compares = 0;
    void'($urandom(32'hE234D7F4));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset state
    apb(1'b0, CKRS_OFF_RST, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, CKRS_OFF_INT, 32'h0);
    `CHK(rd, 32'h00000000)
    `CHK(clk_irq, 1'b0)
    // Reset register: all defined bits, random, all zero; software keeps reserved bits zero
    for (i = 0; i < 10; i++) begin
      d = (i == 0) ? CKRS_RST_MASK : ((i == 9) ? 32'h0 : ($urandom & CKRS_RST_MASK));
      apb(1'b1, CKRS_OFF_RST, d);
      `CHK(err, 1'b0)
      apb(1'b0, CKRS_OFF_RST, 32'h0);
      `CHK(rd, exp_rst(d))
      `CHK(rst_out, exp_rst(d))
    end
    // Enable bits read back; clear bits read zero
    for (i = 0; i < 4; i++) begin
      d = $urandom & 32'h00FF7F00;
      apb(1'b1, CKRS_OFF_INT, d);
      apb(1'b0, CKRS_OFF_INT, 32'h0);
      `CHK(rd, d & 32'h00007F00)
    end
    // Unmapped address is refused
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // Each flag: gating (five ready flags only), set, interrupt, masking, clear
    for (i = 0; i < 8; i++) begin
      en = (i < 5) ? (32'h100 << i) : 32'h0;
      apb(1'b1, CKRS_OFF_IEN, 32'h1 << i);
      apb(1'b1, CKRS_OFF_INT, 32'h0);
      if (i < 5) begin
        pulse(i);
        apb(1'b0, CKRS_OFF_INT, 32'h0);
        `CHK(rd, 32'h0)
      end
      apb(1'b1, CKRS_OFF_INT, en);
      pulse(i);
      apb(1'b0, CKRS_OFF_INT, 32'h0);
      `CHK(rd, en | (32'h1 << i))
      `CHK(clk_irq, 1'b1)
      apb(1'b1, CKRS_OFF_IEN, 32'h0);
      repeat (2) @(posedge clk);
      `CHK(clk_irq, 1'b0)
      apb(1'b1, CKRS_OFF_IEN, 32'h1 << i);
      apb(1'b1, CKRS_OFF_INT, en | (32'h1 << (16 + i)));
      apb(1'b0, CKRS_OFF_INT, 32'h0);
      `CHK(rd, en)
      `CHK(clk_irq, 1'b0)
    end
    // Monitor interrupt enable also clears the crystal stuck flag
    pulse(7);
    apb(1'b0, CKRS_OFF_INT, 32'h0);
    `CHK(rd[7], 1'b1)
    apb(1'b1, CKRS_OFF_MON, 32'h1);
    apb(1'b0, CKRS_OFF_INT, 32'h0);
    `CHK(rd[7], 1'b0)
    apb(1'b0, CKRS_OFF_MON, 32'h0);
    `CHK(rd, 32'h00000001)
    apb(1'b0, CKRS_OFF_IEN, 32'h0);
    `CHK(rd, 32'h00000080)
    wrap_up();
  end
endmodule : tb
